// File: rtl/cmf_consts.vh
// Constants for the main clock monitor and fallback block.
`ifndef CMF_CONSTS_VH
`define CMF_CONSTS_VH

// ==================================================================
// Register byte offsets
`define CMF_OFS_OSC_MODE 12'h000
`define CMF_OFS_MON_MODE 12'h004
`define CMF_OFS_STAB_SEL 12'h008
`define CMF_OFS_WDT_MODE 12'h00C
`define CMF_OFS_STATUS 12'h010

// ==================================================================
// Field positions and widths
`define CMF_BIT_OSC_STOP 0
`define CMF_BIT_MON_EN 0
`define CMF_STAB_SEL_W 4
`define CMF_WDT_MODE_W 3
`define CMF_ST_FALLBACK 0
`define CMF_ST_MONITOR 1
`define CMF_ST_STAB_WAIT 2
`define CMF_ST_OSC_RUN 3
`define CMF_ST_MAIN_RUN 4

// ==================================================================
// Reset values
`define CMF_RST_OSC_MODE 8'h00
`define CMF_RST_MON_MODE 8'h00
`define CMF_RST_STAB_SEL 4'h0
`define CMF_RST_WDT_MODE 3'h0

// ==================================================================
// Timing counts as powers of two, then counter widths and the supervision window in cycles
`define CMF_STAB_RST_EXP 5'h0D
`define CMF_STAB_RST_LONG_EXP 5'h0F
`define CMF_STAB_STOP_MIN_EXP 5'h0D
`define CMF_STAB_STOP_MAX_EXP 5'h15
`define CMF_WDT_RST_EXP 5'h13
`define CMF_WDT_STOP_MIN_EXP 5'h0C
`define CMF_TIMER_W 22
`define CMF_MON_WINDOW 6'h10
`define CMF_MON_W 6

// ==================================================================
// Bus responses
`define CMF_RESP_OKAY 2'h0
`define CMF_RESP_DECERR 2'h3

`endif

// File: rtl/cmf_edge_watch.v
// Pin synchroniser that reports each settled change of the main clock.
`timescale 1ns/100ps
module cmf_edge_watch (
    input wire aclk,
    input wire aresetn,
    input wire pin_in,
    output reg level,
    output reg change
);
    reg sync_a;
    reg sync_b;
    reg sync_c;

    // ==================================================================
    // Three stages; a change counts once the second and third agree.
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
            level <= 1'b0;
            change <= 1'b0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
            change <= 1'b0;
            if (sync_b == sync_c && sync_c != level) begin
                level <= sync_c;
                change <= 1'b1;
            end
        end
    end
endmodule // cmf_edge_watch

// File: rtl/cmf_pow2_timer.v
// Counter that flags completion after two to the power exp ticks.
`timescale 1ns/100ps
`include "cmf_consts.vh"
module cmf_pow2_timer (
    input wire aclk,
    input wire aresetn,
    input wire clear,
    input wire tick,
    input wire [4:0] exp,
    output reg done
);
    reg [`CMF_TIMER_W-1:0] count;
    wire [`CMF_TIMER_W-1:0] limit;

    assign limit = ({{(`CMF_TIMER_W-1){1'b0}}, 1'b1} << exp) - {{(`CMF_TIMER_W-1){1'b0}}, 1'b1};

    // ==================================================================
    // Counting; done stays high until the next clear.
    always @(posedge aclk) begin
        if (!aresetn || clear) begin
            count <= {`CMF_TIMER_W{1'b0}};
            done <= 1'b0;
        end else if (tick && !done) begin
            if (count == limit) begin
                done <= 1'b1;
            end else begin
                count <= count + {{(`CMF_TIMER_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // cmf_pow2_timer

// File: rtl/cmf_clock_monitor.v
// Main clock monitor with internal oscillator fallback and AXI4-Lite registers.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "cmf_consts.vh"
module cmf_clock_monitor #(
    parameter [4:0] EXP_REDUCE = 5'h00
) (
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire main_clk_pin,
    input wire osc_stop_permit,
    input wire stab_long_option,
    input wire stop_request,
    input wire stop_release,
    input wire main_osc_stop,
    input wire cpu_on_subclock_flag,
    output reg monitor_reset,
    output reg fallback_active_flag,
    output reg int_osc_enable,
    output reg main_osc_enable
);
    localparam [1:0] ST_WAIT = 2'b00;
    localparam [1:0] ST_RUN = 2'b01;
    localparam [1:0] ST_STOP = 2'b10;
    localparam [1:0] ST_FALLBACK = 2'b11;

    reg [7:0] internal_osc_mode;
    reg [7:0] monitor_mode_reg;
    reg [`CMF_STAB_SEL_W-1:0] stabilization_select;
    reg [`CMF_WDT_MODE_W-1:0] watchdog2_mode;
    reg [1:0] state;
    reg [1:0] next_state;
    reg from_stop;
    reg main_paused;
    reg [`CMF_MON_W-1:0] window_count;
    reg [4:0] stab_exp;
    reg [4:0] wdt_exp;
    reg [4:0] stop_stab_exp;
    reg [7:0] read_value;
    reg read_hit;
    reg write_hit;
    wire main_level;
    wire main_change;
    wire stab_done;
    wire wdt_done;
    wire in_wait;
    wire monitor_active;
    wire write_fire;
    wire read_fire;

    // ==================================================================
    // Main clock sampling, the stabilization timer and watchdog two.
    cmf_edge_watch u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(main_clk_pin),
        .level(main_level),
        .change(main_change)
    );

    assign in_wait = (state == ST_WAIT);

    always @* begin
        stop_stab_exp = `CMF_STAB_STOP_MIN_EXP + {1'b0, stabilization_select};
        if (stop_stab_exp > `CMF_STAB_STOP_MAX_EXP) begin
            stop_stab_exp = `CMF_STAB_STOP_MAX_EXP;
        end
        if (from_stop) begin
            stab_exp = stop_stab_exp - EXP_REDUCE;
            wdt_exp = `CMF_WDT_STOP_MIN_EXP + {2'b00, watchdog2_mode} - EXP_REDUCE;
        end else begin
            stab_exp = (stab_long_option ? `CMF_STAB_RST_LONG_EXP
                                         : `CMF_STAB_RST_EXP) - EXP_REDUCE;
            wdt_exp = `CMF_WDT_RST_EXP - EXP_REDUCE;
        end
    end

    // Stabilization counts main clock cycles.
    cmf_pow2_timer u_stab (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(!in_wait),
        .tick(main_change && main_level),
        .exp(stab_exp),
        .done(stab_done)
    );

    // Watchdog two counts internal oscillator cycles.
    cmf_pow2_timer u_wdt (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(!in_wait),
        .tick(int_osc_enable),
        .exp(wdt_exp),
        .done(wdt_done)
    );

    // ==================================================================
    // Operating state.
    always @* begin
        next_state = state;
        case (state)
            ST_WAIT: begin
                if (stab_done) begin
                    next_state = ST_RUN;
                end else if (wdt_done) begin
                    next_state = ST_FALLBACK;
                end
            end
            ST_RUN: begin
                if (stop_request) begin
                    next_state = ST_STOP;
                end
            end
            ST_STOP: begin
                if (stop_release) begin
                    next_state = ST_WAIT;
                end
            end
            ST_FALLBACK: begin
                next_state = ST_FALLBACK;
            end
            default: begin
                next_state = ST_WAIT;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_WAIT;
            from_stop <= 1'b0;
            fallback_active_flag <= 1'b0;
            main_osc_enable <= 1'b0;
            int_osc_enable <= 1'b0;
            main_paused <= 1'b0;
        end else begin
            state <= next_state;
            if (state == ST_STOP && stop_release) begin
                from_stop <= 1'b1;
            end
            fallback_active_flag <= (next_state == ST_FALLBACK);
            main_osc_enable <= (next_state != ST_STOP);
            int_osc_enable <= !(internal_osc_mode[`CMF_BIT_OSC_STOP] && osc_stop_permit);
            if (main_osc_stop && cpu_on_subclock_flag) begin
                main_paused <= 1'b1;
            end else if (!main_osc_stop && !cpu_on_subclock_flag) begin
                main_paused <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Supervision window.
    assign monitor_active = monitor_mode_reg[`CMF_BIT_MON_EN]
                            && state == ST_RUN
                            && !fallback_active_flag
                            && !main_paused
                            && int_osc_enable;

    always @(posedge aclk) begin
        if (!aresetn) begin
            window_count <= {`CMF_MON_W{1'b0}};
            monitor_reset <= 1'b0;
        end else begin
            monitor_reset <= 1'b0;
            if (!monitor_active || main_change) begin
                window_count <= {`CMF_MON_W{1'b0}};
            end else if (window_count == `CMF_MON_WINDOW - 6'h01) begin
                window_count <= {`CMF_MON_W{1'b0}};
                monitor_reset <= 1'b1;
            end else begin
                window_count <= window_count + 6'h01;
            end
        end
    end

    // ==================================================================
    // AXI4-Lite write channel.
    assign write_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    always @* begin
        case (s_axi_awaddr)
            `CMF_OFS_OSC_MODE, `CMF_OFS_MON_MODE, `CMF_OFS_STAB_SEL,
            `CMF_OFS_WDT_MODE, `CMF_OFS_STATUS: write_hit = 1'b1;
            default: write_hit = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CMF_RESP_OKAY;
            internal_osc_mode <= `CMF_RST_OSC_MODE;
            monitor_mode_reg <= `CMF_RST_MON_MODE;
            stabilization_select <= `CMF_RST_STAB_SEL;
            watchdog2_mode <= `CMF_RST_WDT_MODE;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (!s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (write_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= write_hit ? `CMF_RESP_OKAY : `CMF_RESP_DECERR;
                if (s_axi_wstrb[0]) begin
                    case (s_axi_awaddr)
                        `CMF_OFS_OSC_MODE: begin
                            internal_osc_mode <= {7'h00, s_axi_wdata[`CMF_BIT_OSC_STOP]};
                        end
                        `CMF_OFS_MON_MODE: begin
                            if (s_axi_wdata[`CMF_BIT_MON_EN]) begin
                                monitor_mode_reg <= 8'h01;
                            end
                        end
                        `CMF_OFS_STAB_SEL: begin
                            stabilization_select <= s_axi_wdata[`CMF_STAB_SEL_W-1:0];
                        end
                        `CMF_OFS_WDT_MODE: begin
                            watchdog2_mode <= s_axi_wdata[`CMF_WDT_MODE_W-1:0];
                        end
                        default: begin
                            internal_osc_mode <= internal_osc_mode;
                        end
                    endcase
                end
            end
        end
    end

    // ==================================================================
    // AXI4-Lite read channel.
    assign read_fire = s_axi_arvalid && s_axi_arready;

    always @* begin
        read_hit = 1'b1;
        read_value = 8'h00;
        case (s_axi_araddr)
            `CMF_OFS_OSC_MODE: read_value = internal_osc_mode;
            `CMF_OFS_MON_MODE: read_value = monitor_mode_reg;
            `CMF_OFS_STAB_SEL: read_value = {4'h0, stabilization_select};
            `CMF_OFS_WDT_MODE: read_value = {5'h00, watchdog2_mode};
            `CMF_OFS_STATUS: begin
                read_value[`CMF_ST_FALLBACK] = fallback_active_flag;
                read_value[`CMF_ST_MONITOR] = monitor_active;
                read_value[`CMF_ST_STAB_WAIT] = in_wait;
                read_value[`CMF_ST_OSC_RUN] = int_osc_enable;
                read_value[`CMF_ST_MAIN_RUN] = main_osc_enable;
            end
            default: read_hit = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CMF_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (read_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, read_value};
                s_axi_rresp <= read_hit ? `CMF_RESP_OKAY : `CMF_RESP_DECERR;
            end
        end
    end
endmodule // cmf_clock_monitor

// File: testbench/cmf_monitor.sv
// Concurrent checks on the ports of the main clock monitor block.
`timescale 1ns/100ps
`include "cmf_consts.vh"
module cmf_checker #(
    parameter [4:0] EXP_REDUCE = 5'h00
) (
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire main_osc_stop,
    input wire cpu_on_subclock_flag,
    input wire monitor_reset,
    input wire fallback_active_flag,
    input wire int_osc_enable,
    input wire main_osc_enable
);
// ================================================================
// Helper state.
default clocking cb @(posedge aclk); endclocking
reg en_seen;
wire held = main_osc_stop && cpu_on_subclock_flag;
always @(posedge aclk) begin
    if (!aresetn) begin
        en_seen <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wstrb[0] && s_axi_wdata[0]
                 && s_axi_awaddr == `CMF_OFS_MON_MODE) begin
        en_seen <= 1'b1;
    end
end
// ================================================================
// Assertions.
chk_reset_quiet:
    assert property (!aresetn |=> !(monitor_reset || fallback_active_flag || int_osc_enable
        || main_osc_enable)) else $error("output active during reset");
chk_release_run:
    assert property (disable iff (!aresetn) $rose(aresetn) |=> int_osc_enable && main_osc_enable)
        else $error("oscillators not started after reset");
chk_enable_first:
    assert property (disable iff (!aresetn) !en_seen |-> !monitor_reset)
        else $error("monitor reset before enable written");
chk_pulse_single:
    assert property (disable iff (!aresetn) monitor_reset |=> !monitor_reset)
        else $error("monitor reset longer than one cycle");
chk_fallback_quiet:
    assert property (disable iff (!aresetn) fallback_active_flag |-> !monitor_reset)
        else $error("monitor reset in fallback");
chk_fallback_hold:
    assert property (disable iff (!aresetn) fallback_active_flag |=> fallback_active_flag)
        else $error("fallback left without reset");
chk_osc_off_quiet:
    assert property (disable iff (!aresetn) !int_osc_enable && !$past(int_osc_enable)
        |-> !monitor_reset) else $error("monitor reset with sampling clock stopped");
chk_stop_quiet:
    assert property (disable iff (!aresetn) !main_osc_enable && !$past(main_osc_enable)
        |-> !monitor_reset) else $error("monitor reset in stop");
chk_pause_quiet:
    assert property (disable iff (!aresetn) $past(held, 2) && $past(held) |-> !monitor_reset)
        else $error("monitor reset while main clock paused");
cover property (disable iff (!aresetn) monitor_reset);
cover property (disable iff (!aresetn) $rose(fallback_active_flag));
cover property (disable iff (!aresetn) $fell(main_osc_enable));
endmodule // cmf_checker

bind cmf_clock_monitor cmf_checker #(.EXP_REDUCE(EXP_REDUCE)) chk_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .main_osc_stop(main_osc_stop),
    .cpu_on_subclock_flag(cpu_on_subclock_flag), .monitor_reset(monitor_reset),
    .fallback_active_flag(fallback_active_flag), .int_osc_enable(int_osc_enable),
    .main_osc_enable(main_osc_enable));

// File: testbench/cmf_osc_model.sv
// Main oscillator and system reset generator facing the block.
`timescale 1ns/100ps
module cmf_osc_model (
    input wire aclk,
    input wire rst_req,
    input wire osc_en,
    input wire osc_fail,
    output logic main_clk_pin,
    output logic aresetn
);
int hold;
int phase;
initial begin
    main_clk_pin = 1'b0;
    aresetn = 1'b0;
    hold = 12;
    phase = 0;
end
// The crystal swings only while enabled and healthy; otherwise the pin freezes.
// It moves on the falling edge, so the block never samples it as it changes.
always @(negedge aclk) begin
    if (osc_en && !osc_fail) begin
        if (phase == 2) begin
            phase <= 0;
            main_clk_pin <= ~main_clk_pin;
        end else begin
            phase <= phase + 1;
        end
    end
end
// Reset is held for twelve clock cycles after each request.
always @(posedge aclk) begin
    if (rst_req) begin
        hold <= 12;
    end else if (hold > 0) begin
        hold <= hold - 1;
    end
    aresetn <= !rst_req && hold <= 1;
end
endmodule // cmf_osc_model

// File: testbench/tb.sv
// Self-checking testbench of the main clock monitor block.
`timescale 1ns/100ps
`include "cmf_consts.vh"
module tb;
logic aclk = 1'b0;
logic rst_req = 1'b0, osc_fail = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
logic arvalid = 1'b0, rready = 1'b0, permit = 1'b0, stop_req = 1'b0, stop_rel = 1'b0;
logic mstop = 1'b0, on_sub = 1'b0, long_opt = 1'b0;
logic [11:0] awaddr = 12'h000, araddr = 12'h000;
logic [31:0] wdata = 32'h00000000, rd;
logic [1:0] rs;
wire aresetn, main_clk_pin, awready, wready, bvalid, arready, rvalid;
wire mon_rst, fb_flag, io_en, mo_en;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
int fails = 0, comparisons = 0, cyc = 0;
always #20 aclk = ~aclk;
cmf_clock_monitor #(.EXP_REDUCE(5'h09)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .main_clk_pin(main_clk_pin), .osc_stop_permit(permit), .stab_long_option(long_opt),
    .stop_request(stop_req), .stop_release(stop_rel), .main_osc_stop(mstop),
    .cpu_on_subclock_flag(on_sub), .monitor_reset(mon_rst), .fallback_active_flag(fb_flag),
    .int_osc_enable(io_en), .main_osc_enable(mo_en));
cmf_osc_model osc_u (.aclk(aclk), .rst_req(rst_req), .osc_en(mo_en), .osc_fail(osc_fail),
    .main_clk_pin(main_clk_pin), .aresetn(aresetn));
// ================================================================
// Bus and comparison tasks.
task automatic results();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask
task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
        fails++;
        $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
endtask
task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp({30'h0, got}, {30'h0, exp});
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
endtask
task automatic rd_reg(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
endtask
task automatic watch(input int n, output int hits);
    hits = 0;
    repeat (n) begin
        @(posedge aclk);
        if (mon_rst === 1'b1) hits++;
    end
endtask
task automatic wait_stab();
    rd = 32'h00000004;
    for (int i = 0; i < 100 && rd[`CMF_ST_STAB_WAIT] !== 1'b0; i++) rd_reg(`CMF_OFS_STATUS);
endtask
task automatic pulse_stop(input logic rel);
    int h;
    if (rel) stop_rel <= 1'b1;
    else stop_req <= 1'b1;
    watch(1, h);
    stop_rel <= 1'b0;
    stop_req <= 1'b0;
    watch(2, h);
endtask
task automatic fail_check(input int n, input logic expect_hit);
    int h;
    osc_fail <= 1'b1;
    watch(n, h);
    osc_fail <= 1'b0;
    cmp(32'(h > 0), {31'h0, expect_hit});
endtask
// ================================================================
// Scenarios.
task automatic t_regs();
    rd_reg(`CMF_OFS_OSC_MODE);
    cmp(rd, 32'h00000000);
    rd_reg(`CMF_OFS_MON_MODE);
    cmp(rd, 32'h00000000);
    rd_reg(12'h014);
    cmp_resp(rs, `CMF_RESP_DECERR);
    wr(12'h020, 32'h000000FF);
    cmp_resp(rs, `CMF_RESP_DECERR);
    wait_stab();
    cmp(rd, 32'h00000018);
    $display("test regs done");
endtask
task automatic t_enable();
    fail_check(40, 1'b0);
    wr(`CMF_OFS_MON_MODE, 32'h1);
    wr(`CMF_OFS_MON_MODE, 32'h0);
    rd_reg(`CMF_OFS_MON_MODE);
    cmp(rd, 32'h00000001);
    fail_check(40, 1'b1);
    $display("test enable done");
endtask
task automatic t_pause();
    int h;
    mstop <= 1'b1;
    on_sub <= 1'b1;
    watch(3, h);
    fail_check(60, 1'b0);
    mstop <= 1'b0;
    on_sub <= 1'b0;
    watch(6, h);
    fail_check(40, 1'b1);
    $display("test pause done");
endtask
task automatic t_osc_stop();
    int h;
    wr(`CMF_OFS_OSC_MODE, 32'h1);
    cmp({31'h0, io_en}, 32'h1);
    permit <= 1'b1;
    watch(3, h);
    cmp({31'h0, io_en}, 32'h0);
    fail_check(40, 1'b0);
    permit <= 1'b0;
    rd_reg(`CMF_OFS_OSC_MODE);
    cmp(rd, 32'h00000001);
    wr(`CMF_OFS_OSC_MODE, 32'h0);
    $display("test oscillator stop done");
endtask
task automatic t_stop();
    wr(`CMF_OFS_WDT_MODE, 32'h7);
    pulse_stop(1'b0);
    cmp({31'h0, mo_en}, 32'h0);
    fail_check(60, 1'b0);
    pulse_stop(1'b1);
    rd_reg(`CMF_OFS_STATUS);
    cmp(rd & 32'h6, 32'h00000004);
    wait_stab();
    cmp(rd, 32'h0000001A);
    fail_check(40, 1'b1);
    $display("test stop done");
endtask
task automatic t_fallback();
    int h;
    wr(`CMF_OFS_WDT_MODE, 32'h0);
    pulse_stop(1'b0);
    pulse_stop(1'b1);
    watch(30, h);
    cmp({31'h0, fb_flag}, 32'h1);
    fail_check(60, 1'b0);
    cmp({31'h0, fb_flag}, 32'h1);
    rst_req <= 1'b1;
    long_opt <= 1'b1;
    watch(1, h);
    rst_req <= 1'b0;
    watch(16, h);
    watch(140, h);
    rd_reg(`CMF_OFS_STATUS);
    cmp(rd & 32'h4, 32'h00000004);
    wait_stab();
    cmp(rd, 32'h00000018);
    rd_reg(`CMF_OFS_MON_MODE);
    cmp(rd, 32'h00000000);
    $display("test fallback done");
endtask
initial begin
    while (aresetn !== 1'b1) @(posedge aclk);
    t_regs();
    t_enable();
    t_pause();
    t_osc_stop();
    t_stop();
    t_fallback();
    results();
end
always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        fails = fails + 1;
        results();
    end
end
endmodule // tb
